/* design/sas_pins.sv */
// shared port/analog pin muxing, one slice per pin
module sas_pins #(
   parameter int N = 4
) (
   input  wire logic [N-1:0] dir_i,
   input  wire logic [N-1:0] func_i,
   input  wire logic [N-1:0] latch_i,
   input  wire logic [N-1:0] pad_in_i,
   output logic [N-1:0]      pad_out_o,
   output logic [N-1:0]      pad_oe_n_o,
   output logic [N-1:0]      port_din_o,
   output logic [N-1:0]      ana_connect_o
);

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pin
         // drive only in port mode with direction zero
         assign pad_oe_n_o[g]    = ~(~dir_i[g] & ~func_i[g]);  // [R3] [R4]
         assign pad_out_o[g]     = latch_i[g];
         // digital read blocked while pin serves the analog input
         assign port_din_o[g]    = pad_in_i[g] & ~func_i[g];  // [R4]
         assign ana_connect_o[g] = func_i[g];  // [R4]
      end
   endgenerate

endmodule : sas_pins

/* design/sas_pkg.sv */
// shared constants, carriers and timing table for the converter sequencer
package sas_pkg;

   // ****************************************
   // register addresses
   // ****************************************
   localparam logic [15:0] SAS_ADDR_RES_LO   = 16'hff18;
   localparam logic [15:0] SAS_ADDR_RES_HI   = 16'hff19;
   localparam logic [15:0] SAS_ADDR_RES_BYTE = 16'hff1a;
   localparam logic [15:0] SAS_ADDR_DIR      = 16'hff22;
   localparam logic [15:0] SAS_ADDR_MODE     = 16'hff80;
   localparam logic [15:0] SAS_ADDR_CHAN     = 16'hff81;
   localparam logic [15:0] SAS_ADDR_FUNC     = 16'hff84;

   // ****************************************
   // reset values and fixed bits
   // ****************************************
   localparam logic [7:0] SAS_DIR_RST   = 8'hff;
   localparam logic [7:0] SAS_FUNC_RST  = 8'h00;
   localparam logic [7:0] SAS_MODE_RST  = 8'h00;
   localparam logic [7:0] SAS_CHAN_RST  = 8'h00;
   localparam logic [7:0] SAS_DIR_FIXED = 8'hf0;  // upper direction bits read one
   localparam logic [7:0] SAS_MODE_MASK = 8'hb9;  // bits 6, 2, 1 read zero
   localparam logic [7:0] SAS_CHAN_MASK = 8'h03;
   localparam logic [7:0] SAS_PIN_MASK  = 8'h0f;

   // ****************************************
   // field positions
   // ****************************************
   localparam int SAS_RUN_BIT  = 7;
   localparam int SAS_CMP_BIT  = 0;
   localparam int SAS_TIME_LSB = 3;
   localparam int SAS_TIME_MSB = 5;
   localparam int SAS_CHAN_LSB = 0;
   localparam int SAS_CHAN_MSB = 1;

   // ****************************************
   // approximation
   // ****************************************
   localparam int          SAS_RES_W    = 10;
   localparam logic [9:0]  SAS_SAR_INIT = 10'h200;  // msb trial, half scale
   localparam logic [3:0]  SAS_POS_MSB  = 4'h9;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } sas_bus_s;

   typedef struct packed {
      logic       cmp_en;
      logic       sample;
      logic [1:0] chan;
      logic [9:0] tap;
   } sas_ana_s;

   // cycles of the peripheral clock: sampling, per bit, tail padding
   typedef struct packed {
      logic [7:0] samp;
      logic [7:0] bitc;
      logic [7:0] tail;
   } sas_timing_s;

   // step counts per time code: sampling / total cycles in the trailing note
   localparam sas_timing_s SAS_TIM_C1   = '{8'h18, 8'h02, 8'h04};  // 24 / 48
   localparam sas_timing_s SAS_TIM_C2   = '{8'h30, 8'h02, 8'h04};  // 48 / 72
   localparam sas_timing_s SAS_TIM_C3   = '{8'h58, 8'h02, 8'h04};  // 88 / 112
   localparam sas_timing_s SAS_TIM_C5   = '{8'h30, 8'h04, 8'h08};  // 48 / 96
   localparam sas_timing_s SAS_TIM_C6   = '{8'h60, 8'h04, 8'h08};  // 96 / 144
   localparam sas_timing_s SAS_TIM_SLOW = '{8'hb0, 8'h04, 8'h08};  // 176 / 224, codes 0, 4, 7

   // sampling and conversion cycles per time code (total = samp + 10*bitc + tail)
   function automatic sas_timing_s sas_timing(input logic [2:0] code);
      sas_timing_s t;
      case (code)
         3'h1:    t = SAS_TIM_C1;
         3'h2:    t = SAS_TIM_C2;
         3'h3:    t = SAS_TIM_C3;
         3'h5:    t = SAS_TIM_C5;
         3'h6:    t = SAS_TIM_C6;
         default: t = SAS_TIM_SLOW;
      endcase
      return t;
   endfunction : sas_timing

endpackage : sas_pkg

/* design/sas_sar.sv */
// successive approximation register, one bit decided per decide strobe
module sas_sar
   import sas_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire logic       srst_i,
   input  wire logic       start_i,
   input  wire logic       decide_i,
   input  wire logic       cmp_i,
   output logic [9:0]      trial_o,
   output logic            last_o
);

   logic [9:0] trial_reg;
   logic [9:0] trial_next;
   logic [3:0] pos_reg;
   logic [3:0] pos_next;

   // next trial value and bit position
   always_comb begin
      trial_next = trial_reg;
      pos_next   = pos_reg;
      if (start_i) begin
         trial_next = SAS_SAR_INIT;  // [R7]
         pos_next   = SAS_POS_MSB;
      end else if (decide_i) begin
         trial_next[pos_reg] = cmp_i;  // keep only when input at or above tap [R7] [R8]
         if (pos_reg != 4'h0) begin
            trial_next[pos_reg - 4'h1] = 1'b1;  // next trial picks tap from decided bits [R8]
            pos_next = pos_reg - 4'h1;
         end
      end
   end

   // registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         trial_reg <= 10'h000;
         pos_reg   <= 4'h0;
      end else begin
         trial_reg <= trial_next;
         pos_reg   <= pos_next;
      end
   end

   assign trial_o = trial_reg;
   assign last_o  = (pos_reg == 4'h0);  // [R9]

endmodule : sas_sar

/* design/sas_top.sv */
// converter sequencer: registers, conversion state machine, results
//
// Behaviour
// [R1] software sets function and direction for analog
// [R2] reset: function register zero, direction all ones
// [R3] direction zero drives pin, one releases
// [R4] function bit one removes digital port use
// [R5] run bit seven starts selected channel
// [R6] sample fixed time, then hold to end
// [R7] bit nine tried first at half scale
// [R8] later bits tried from decided bits
// [R9] after ten bits latch results, pulse done
// [R10] conversions repeat until run bit cleared
// [R11] mode or channel write restarts conversion
// [R12] clearing run bit stops conversion at once
// [R13] result registers have no reset value
// [R14] ideal code is input ratio times 1024
// [R15] word result and high byte result
// [R16] software waits 1 us after comparator enable
// [R17] software waits two cycles before run
// [R18] software drops first result without comparator
// [R19] fixed field positions in mode, channel
// [R20] channel change to done is full time
// [R21] software restart sequence depends on comparator
// [R22] byte result holds upper eight bits
// [R23] channel code selects inputs in binary
// [R24] control write beats conversion end
// [R25] result read beats conversion end
// [R26] one bit per step, counts from code
module sas_top
   import sas_pkg::*;
#(
   parameter int PINS = 4
) (
   input  wire logic          clk_sys_i,
   input  wire sas_pkg::sas_bus_s bus_i,
   input  wire logic          srst_i,
   input  wire logic          cmp_i,
   input  wire logic [PINS-1:0] port_latch_i,
   input  wire logic [PINS-1:0] pad_in_i,
   output logic [7:0]         rdata_o,
   output sas_pkg::sas_ana_s  ana_o,
   output logic               done_irq_o,
   output logic [PINS-1:0]    pad_out_o,
   output logic [PINS-1:0]    pad_oe_n_o,
   output logic [PINS-1:0]    port_din_o,
   output logic [PINS-1:0]    ana_connect_o
);
   import sas_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   typedef enum logic [3:0] {
      SAS_IDLE   = 4'b0001,
      SAS_SAMPLE = 4'b0010,
      SAS_CONV   = 4'b0100,
      SAS_TAIL   = 4'b1000
   } sas_state_e;

   sas_state_e  state_reg;
   sas_state_e  state_next;
   logic [7:0]  cnt_reg;
   logic [7:0]  cnt_next;
   logic [7:0]  mode_reg;
   logic [7:0]  mode_next;
   logic [7:0]  chan_reg;
   logic [7:0]  chan_next;
   logic [7:0]  dir_reg;
   logic [7:0]  dir_next;
   logic [7:0]  func_reg;
   logic [7:0]  func_next;
   logic [7:0]  rdata_reg;
   logic [7:0]  rdata_next;
   logic        done_reg;
   logic        done_next;
   logic [9:0]  result_word_reg;
   logic [7:0]  result_high_byte_reg;
   logic        ctl_wr;
   logic        run_now;
   logic        sar_start;
   logic        sar_decide;
   logic [9:0]  sar_trial;
   logic        sar_last;
   logic        finish;
   sas_timing_s tm;

   // address match, shared by write and read decode
   function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
      return a == ref_a;
   endfunction : hit

   // ****************************************
   // register writes
   // ****************************************

   // next values of software registers
   always_comb begin
      mode_next = mode_reg;
      chan_next = chan_reg;
      dir_next  = dir_reg;
      func_next = func_reg;
      if (bus_i.wr) begin
         if (hit(bus_i.addr, SAS_ADDR_MODE)) begin
            mode_next = bus_i.wdata & SAS_MODE_MASK;  // [R19]
         end else if (hit(bus_i.addr, SAS_ADDR_CHAN)) begin
            chan_next = bus_i.wdata & SAS_CHAN_MASK;  // [R19] [R23]
         end else if (hit(bus_i.addr, SAS_ADDR_DIR)) begin
            dir_next = (bus_i.wdata & SAS_PIN_MASK) | SAS_DIR_FIXED;
         end else if (hit(bus_i.addr, SAS_ADDR_FUNC)) begin
            func_next = bus_i.wdata & SAS_PIN_MASK;
         end
      end
   end

   // software registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         mode_reg <= SAS_MODE_RST;
         chan_reg <= SAS_CHAN_RST;
         dir_reg  <= SAS_DIR_RST;   // [R2]
         func_reg <= SAS_FUNC_RST;  // [R2]
      end else begin
         mode_reg <= mode_next;
         chan_reg <= chan_next;
         dir_reg  <= dir_next;
         func_reg <= func_next;
      end
   end

   // a control write aborts whatever conversion is running
   assign ctl_wr  = bus_i.wr & (hit(bus_i.addr, SAS_ADDR_MODE) | hit(bus_i.addr, SAS_ADDR_CHAN));  // [R11]
   assign run_now = mode_next[SAS_RUN_BIT];
   assign tm      = sas_timing(mode_next[SAS_TIME_MSB:SAS_TIME_LSB]);  // [R26]

   // ****************************************
   // conversion sequencer
   // ****************************************

   // state, step counter, sar strobes
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      sar_start  = 1'b0;
      sar_decide = 1'b0;
      finish     = 1'b0;
      if (ctl_wr) begin
         // restart from sampling, or stop when run cleared
         if (run_now) begin
            state_next = SAS_SAMPLE;  // [R11] [R20]
            cnt_next   = tm.samp - 8'h01;
         end else begin
            state_next = SAS_IDLE;  // [R12]
            cnt_next   = 8'h00;
         end
      end else begin
         case (state_reg)
            SAS_IDLE: begin
               if (run_now) begin
                  state_next = SAS_SAMPLE;  // [R5]
                  cnt_next   = tm.samp - 8'h01;
               end
            end
            SAS_SAMPLE: begin
               if (cnt_reg == 8'h00) begin
                  state_next = SAS_CONV;  // [R6]
                  cnt_next   = tm.bitc - 8'h01;
                  sar_start  = 1'b1;  // [R7]
               end else begin
                  cnt_next = cnt_reg - 8'h01;
               end
            end
            SAS_CONV: begin
               if (cnt_reg == 8'h00) begin
                  sar_decide = 1'b1;  // [R8] [R26]
                  if (sar_last) begin
                     state_next = SAS_TAIL;  // every table entry has a nonzero tail
                     cnt_next   = tm.tail - 8'h01;
                  end else begin
                     cnt_next = tm.bitc - 8'h01;
                  end
               end else begin
                  cnt_next = cnt_reg - 8'h01;
               end
            end
            SAS_TAIL: begin
               if (cnt_reg == 8'h00) begin
                  finish     = 1'b1;  // [R9]
                  state_next = SAS_SAMPLE;  // [R10]
                  cnt_next   = tm.samp - 8'h01;
               end else begin
                  cnt_next = cnt_reg - 8'h01;
               end
            end
            default: begin
               state_next = SAS_IDLE;
               cnt_next   = 8'h00;
            end
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state_reg <= SAS_IDLE;
         cnt_reg   <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   sas_sar u_sar (
      .clk_sys_i (clk_sys_i),
      .srst_i    (srst_i),
      .start_i   (sar_start),
      .decide_i  (sar_decide),
      .cmp_i     (cmp_i),
      .trial_o   (sar_trial),
      .last_o    (sar_last)
   );

   // ****************************************
   // results and done pulse
   // ****************************************

   // done pulse only on an undisturbed finish
   assign done_next = finish;  // [R24]

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= done_next;  // [R9]
      end
   end

   // results carry no reset; a read in the same cycle samples the old value
   always_ff @(posedge clk_sys_i) begin
      if (finish) begin
         result_word_reg      <= sar_trial;        // [R9] [R13] [R14] [R15] [R25]
         result_high_byte_reg <= sar_trial[9:2];  // [R15] [R22]
      end
   end

   // ****************************************
   // register reads
   // ****************************************

   // read data mux, registered
   always_comb begin
      rdata_next = rdata_reg;
      if (bus_i.rd) begin
         if (hit(bus_i.addr, SAS_ADDR_MODE)) begin
            rdata_next = mode_reg;
         end else if (hit(bus_i.addr, SAS_ADDR_CHAN)) begin
            rdata_next = chan_reg;
         end else if (hit(bus_i.addr, SAS_ADDR_DIR)) begin
            rdata_next = dir_reg;
         end else if (hit(bus_i.addr, SAS_ADDR_FUNC)) begin
            rdata_next = func_reg;
         end else if (hit(bus_i.addr, SAS_ADDR_RES_LO)) begin
            rdata_next = result_word_reg[7:0];  // [R25]
         end else if (hit(bus_i.addr, SAS_ADDR_RES_HI)) begin
            rdata_next = {6'h00, result_word_reg[9:8]};  // [R15]
         end else if (hit(bus_i.addr, SAS_ADDR_RES_BYTE)) begin
            rdata_next = result_high_byte_reg;  // [R22]
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************

   // analog side: sample while sampling, hold otherwise
   assign ana_o.cmp_en = mode_reg[SAS_CMP_BIT];  // [R19]
   assign ana_o.sample = (state_reg == SAS_SAMPLE);  // [R6]
   assign ana_o.chan   = chan_reg[SAS_CHAN_MSB:SAS_CHAN_LSB];  // [R23]
   assign ana_o.tap    = sar_trial;  // [R7] [R8]
   assign done_irq_o   = done_reg;
   assign rdata_o      = rdata_reg;

   sas_pins #(
      .N (PINS)
   ) u_pins (
      .dir_i         (dir_reg[PINS-1:0]),
      .func_i        (func_reg[PINS-1:0]),
      .latch_i       (port_latch_i),
      .pad_in_i      (pad_in_i),
      .pad_out_o     (pad_out_o),
      .pad_oe_n_o    (pad_oe_n_o),
      .port_din_o    (port_din_o),
      .ana_connect_o (ana_connect_o)
   );

endmodule : sas_top

/* testbench/sas_ana_model.sv */
// behavioural comparator with sample-and-hold and four input levels
module sas_ana_model
   import sas_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire sas_pkg::sas_ana_s ana_i,
   input  wire logic [3:0][9:0]   level_i,
   output logic                   cmp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] held = 10'h000;
   // follow the chosen input while sampling, freeze it in hold
   always @(posedge clk_sys_i) begin
      if (ana_i.sample) held <= level_i[ana_i.chan];
   end
   // input at or above the tap decides a one
   assign cmp_o = (held >= ana_i.tap);
endmodule : sas_ana_model

/* testbench/sas_top_sva.sv */
// port-level assertion checker for the converter sequencer
module sas_top_sva
   import sas_pkg::*;
#(
   parameter int PINS = 4
) (
   input wire logic              clk_sys_i,
   input wire sas_pkg::sas_bus_s bus_i,
   input wire logic              srst_i,
   input wire logic              cmp_i,
   input wire logic [PINS-1:0]   port_latch_i,
   input wire logic [PINS-1:0]   pad_in_i,
   input wire logic [7:0]        rdata_o,
   input wire sas_pkg::sas_ana_s ana_o,
   input wire logic              done_irq_o,
   input wire logic [PINS-1:0]   pad_out_o,
   input wire logic [PINS-1:0]   pad_oe_n_o,
   input wire logic [PINS-1:0]   port_din_o,
   input wire logic [PINS-1:0]   ana_connect_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   logic       mode_wr;
   logic       ctl_wr;
   logic [8:0] cnt_reg, cnt_next, tot_reg, tot_next;
   // control writes restart the conversion timer
   assign mode_wr = bus_i.wr && (bus_i.addr == SAS_ADDR_MODE);
   assign ctl_wr  = mode_wr || (bus_i.wr && (bus_i.addr == SAS_ADDR_CHAN));
   // cycles since start or last done, and programmed total
   always_comb begin
      cnt_next = done_irq_o ? 9'h001 : cnt_reg + 9'h001;
      tot_next = tot_reg;
      if (ctl_wr) cnt_next = 9'h000;
      if (mode_wr) begin
         case (bus_i.wdata[5:3])
            3'h1:    tot_next = 9'h030;
            3'h2:    tot_next = 9'h048;
            3'h3:    tot_next = 9'h070;
            3'h5:    tot_next = 9'h060;
            3'h6:    tot_next = 9'h090;
            default: tot_next = 9'h0e0;
         endcase
      end
   end
   // register the timer
   always_ff @(posedge clk_sys_i) begin
      cnt_reg <= srst_i ? 9'h000 : cnt_next;
      tot_reg <= srst_i ? 9'h0e0 : tot_next;
   end
   // hold begins without a control write behind it
   sequence s_hold_start;
      $fell(ana_o.sample) && !$past(ctl_wr);
   endsequence
   sequence s_stop_write;
      mode_wr && !bus_i.wdata[SAS_RUN_BIT];
   endsequence
   a_reset_pins: assert property (disable iff (1'b0) srst_i |=> (ana_connect_o == '0) && (&pad_oe_n_o))
      else $error("pin registers not at reset values");
   a_din_gate: assert property (port_din_o == (pad_in_i & ~ana_connect_o))
      else $error("port input not gated by function bit");
   a_oe_func: assert property (((ana_connect_o & ~pad_oe_n_o) == '0) && (pad_out_o == port_latch_i))
      else $error("analog pin driven or latch not on pad");
   a_chan_code: assert property (bus_i.wr && (bus_i.addr == SAS_ADDR_CHAN) |=> ana_o.chan == $past(bus_i.wdata[1:0]))
      else $error("channel code not applied");
   a_cmp_enable: assert property (mode_wr |=> ana_o.cmp_en == $past(bus_i.wdata[SAS_CMP_BIT]))
      else $error("comparator enable not applied");
   a_msb_first: assert property (s_hold_start |-> ana_o.tap == SAS_SAR_INIT)
      else $error("first trial not half scale");
   a_done_pulse: assert property (done_irq_o |=> !done_irq_o)
      else $error("done longer than one cycle");
   a_hold_done: assert property (done_irq_o |-> !$past(ana_o.sample, 2))
      else $error("sampling before result latched");
   a_conv_time: assert property (done_irq_o |-> cnt_reg == tot_reg)
      else $error("conversion length wrong");
   a_write_wins: assert property (ctl_wr |=> !done_irq_o)
      else $error("done beside control write");
   a_run_stop: assert property (s_stop_write |=> (!ana_o.sample && !done_irq_o)[*4])
      else $error("conversion not stopped");
endmodule : sas_top_sva

bind sas_top sas_top_sva #(.PINS(PINS)) sas_top_sva_i (
   .clk_sys_i(clk_sys_i), .bus_i(bus_i), .srst_i(srst_i), .cmp_i(cmp_i),
   .port_latch_i(port_latch_i), .pad_in_i(pad_in_i), .rdata_o(rdata_o), .ana_o(ana_o),
   .done_irq_o(done_irq_o), .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
   .port_din_o(port_din_o), .ana_connect_o(ana_connect_o));

/* testbench/sas_top_test.sv */
// self-checking bench for the converter sequencer
module sas_top_test;
   import sas_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic            clk_sys_i = 1'b0;
   logic            srst_i    = 1'b1;
   sas_bus_s        bus       = '0;
   logic [3:0]      latch     = 4'h5;
   logic [3:0]      pad_in    = 4'hf;
   logic [3:0][9:0] level     = {10'h155, 10'h1ff, 10'h3ff, 10'h000};
   int              tab[8]    = '{224, 48, 72, 112, 224, 96, 144, 224};
   logic            cmp, done;
   logic [7:0]      rdata;
   sas_ana_s        ana;
   logic [3:0]      pad_out, oe_n, din, acon;
   int              err_count = 0;
   int              tests_run = 0;
   always #25 clk_sys_i = ~clk_sys_i;
   sas_top sas_top_i (.clk_sys_i(clk_sys_i), .bus_i(bus), .srst_i(srst_i), .cmp_i(cmp),
      .port_latch_i(latch), .pad_in_i(pad_in), .rdata_o(rdata), .ana_o(ana), .done_irq_o(done),
      .pad_out_o(pad_out), .pad_oe_n_o(oe_n), .port_din_o(din), .ana_connect_o(acon));
   sas_ana_model sas_ana_model_i (.clk_sys_i(clk_sys_i), .ana_i(ana), .level_i(level), .cmp_o(cmp));
   // ****
   // bus cycles and comparison
   // ****
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      bus.rd <= 1'b0;
      @(negedge clk_sys_i);
      d = rdata;
   endtask : rd
   task automatic wait_done(output int n);
      n = 0;
      do begin
         @(negedge clk_sys_i);
         n++;
      end while ((done !== 1'b1) && n < 600);
   endtask : wait_done
   task automatic print_verdict;
      $display("tests_run=%0d err_count=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   // ****
   // scenarios
   // ****
   task automatic t_reset;
      logic [7:0] d;
      rd(SAS_ADDR_DIR, d);   chk(d, 8'hff);
      rd(SAS_ADDR_FUNC, d);  chk(d, 8'h00);
      rd(SAS_ADDR_MODE, d);  chk(d, 8'h00);
      rd(16'hff00, d);       chk(d, 8'h00);
      chk(oe_n, 4'hf);
      $display("t_reset finished");
   endtask : t_reset
   task automatic t_pins;
      logic [7:0] d;
      wr(SAS_ADDR_DIR, 8'h0a);
      wr(SAS_ADDR_FUNC, 8'hf3);
      rd(SAS_ADDR_DIR, d);   chk(d, 8'hfa);
      rd(SAS_ADDR_FUNC, d);  chk(d, 8'h03);
      chk(oe_n, 4'hb);
      chk(din, 4'hc);
      chk({pad_out, acon}, {latch, 4'h3});
      @(posedge clk_sys_i);
      pad_in <= 4'h6;
      latch  <= 4'ha;
      @(negedge clk_sys_i);
      chk({pad_out, din}, {4'ha, 4'h4});
      wr(SAS_ADDR_FUNC, 8'h0f);
      wr(SAS_ADDR_DIR, 8'hff);
      chk({oe_n, acon}, 8'hff);
      $display("t_pins finished");
   endtask : t_pins
   task automatic t_conv;
      logic [7:0] lo, hi, hb;
      int n;
      wr(SAS_ADDR_MODE, 8'h09);
      repeat (20) @(posedge clk_sys_i);
      wr(SAS_ADDR_CHAN, 8'h00);
      repeat (2) @(posedge clk_sys_i);
      wr(SAS_ADDR_MODE, 8'h89);
      wait_done(n);  chk(n, 49);
      for (int ch = 0; ch < 4; ch++) begin
         wr(SAS_ADDR_CHAN, 8'(ch));
         wait_done(n);  chk(n, 49);
         rd(SAS_ADDR_RES_LO, lo);
         rd(SAS_ADDR_RES_HI, hi);
         rd(SAS_ADDR_RES_BYTE, hb);
         chk({hi, lo}, {6'h00, level[ch]});
         chk(hb, level[ch][9:2]);
      end
      $display("t_conv finished");
   endtask : t_conv
   task automatic t_codes;
      int n;
      for (int c = 0; c < 8; c++) begin
         wr(SAS_ADDR_MODE, 8'h01 | 8'(c << 3));
         repeat (2) @(posedge clk_sys_i);
         wr(SAS_ADDR_MODE, 8'h81 | 8'(c << 3));
         wait_done(n);  chk(n, tab[c] + 1);
         wait_done(n);  chk(n, tab[c]);
      end
      $display("t_codes finished");
   endtask : t_codes
   task automatic t_stop;
      int n;
      wr(SAS_ADDR_MODE, 8'h89);
      repeat (20) @(posedge clk_sys_i);
      wr(SAS_ADDR_MODE, 8'h09);
      wait_done(n);  chk(n, 600);
      $display("t_stop finished");
   endtask : t_stop
   task automatic t_collide;
      logic [7:0] lo;
      int n;
      wr(SAS_ADDR_MODE, 8'h89);
      wait_done(n);
      // new level for the next conversion, then read on its finish edge
      @(posedge clk_sys_i);
      level[3] <= 10'h2aa;
      repeat (45) @(posedge clk_sys_i);
      rd(SAS_ADDR_RES_LO, lo);  chk(lo, 8'h55);
      rd(SAS_ADDR_RES_LO, lo);  chk(lo, 8'haa);
      // old level back, then a channel write on the next finish edge
      @(posedge clk_sys_i);
      level[3] <= 10'h155;
      repeat (43) @(posedge clk_sys_i);
      wr(SAS_ADDR_CHAN, 8'h02);
      rd(SAS_ADDR_RES_LO, lo);  chk(lo, 8'haa);
      wait_done(n);  chk(n, 46);
      $display("t_collide finished");
   endtask : t_collide
   // main sequence, with a second reset in mid-run
   initial begin
      repeat (12) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      t_reset();
      t_pins();
      t_conv();
      t_codes();
      t_stop();
      t_collide();
      @(posedge clk_sys_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      t_reset();
      print_verdict();
   end
   // watchdog against a hang
   initial begin
      #1000000;
      err_count++;
      print_verdict();
   end
endmodule : sas_top_test
